// *** shared/link_housekeeping_cfg.svh ***
// register offsets, field positions, reset values and timing constants of the link housekeeping block
// assumes the 100 MHz system clock and 8-bit register data
`ifndef LINK_HOUSEKEEPING_CFG_SVH
`define LINK_HOUSEKEEPING_CFG_SVH

// register offsets
`define ADDR_SER_ADDR_COPY   8'h00
`define ADDR_OWN_DEV_ADDR    8'h01
`define ADDR_CTRL_CHAN_EN    8'h04
`define ADDR_OUT_ERR_OPTS    8'h08
`define ADDR_GPIO_STATE      8'h0E
`define ADDR_DET_ERR_CNT     8'h10
`define ADDR_CORR_ERR_CNT    8'h12
`define ADDR_PRBS_ERR_CNT    8'h13

// field positions
`define BIT_FWD_CC_EN        0
`define BIT_REV_CC_EN        1
`define BIT_AUTO_CLR_EN      2
`define BIT_STAGGER_DIS      3
`define BIT_PIN0_IN          0
`define BIT_PIN0_OUT         1
`define BIT_PIN1_IN          2
`define BIT_PIN1_OUT         3

// reset values and the error counter ceiling
`define RST_CC_EN            2'h3
`define RST_PIN_OUT          2'h3
`define RST_AUTO_CLR_EN      1'h0
`define RST_STAGGER_DIS      1'h0
`define ERR_CNT_MAX          8'hFF

// lock supervision: error rate of one in four over a window of symbols
`define WIN_CNT_W            5
`define ERR_WIN_SYMBOLS      5'h10
`define ERR_RATE_DIV         2

// timing, in ns, the clock period and the widths of the two timer counters
`define CLK_PERIOD_NS        10
`define AUTO_CLR_NS          1000
`define REV_HOLD_NS          350000
`define AUTO_CNT_W           8
`define REV_CNT_W            16

// output stagger delays in ps (applied by the output pads)
`define STAG_GRP0_PS         0
`define STAG_GRP1_PS         500
`define STAG_GRP2_PS         1000
`define STAG_GRP3_PS         1500
`define STAG_PCLK_PS         750

`endif

// *** shared/link_housekeeping_pkg.sv ***
// types of the link housekeeping block: the whole state as one packed struct
// assumes the constants header is on the include path
`include "link_housekeeping_cfg.svh"

package link_housekeeping_pkg;

    // register read answer
    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } reg_rsp_t;

    // complete state of the block
    typedef struct packed {
        logic [7:0]               ser_addr;
        logic [7:0]               own_addr;
        logic [1:0]               cc_en;
        logic                     auto_clr_en;
        logic                     stagger_dis;
        logic                     stagger_en;
        logic [1:0]               pin_out;
        logic [1:0]               pin_oe;
        logic [1:0]               pin_s1;
        logic [1:0]               pin_s2;
        logic [1:0]               pin_s3;
        logic [1:0]               pin_lvl;
        logic [7:0]               det_cnt;
        logic [7:0]               corr_cnt;
        logic [7:0]               prbs_cnt;
        logic                     lock;
        logic                     lock_out;
        logic                     relock_req;
        logic [`WIN_CNT_W-1:0]    win_sym;
        logic [`WIN_CNT_W-1:0]    win_err;
        logic                     err_drive;
        logic [`AUTO_CNT_W-1:0]   auto_cnt;
        logic                     sen_d;
        logic [`REV_CNT_W-1:0]    rev_cnt;
        logic                     rev_ready;
        logic                     blocked;
        logic                     ack;
        reg_rsp_t                 rsp;
    } hk_state_t;

endpackage

// *** src/link_housekeeping.sv ***
// link error monitor and housekeeping registers of the serial-link deserializer
// assumes register accesses arrive already decoded from the control channel, one per cycle,
// and that receiver, PRBS checker and control-channel events are pulses on i_clk_sys
`timescale 1ns/1ps

module link_housekeeping
    import link_housekeeping_pkg::*;
#(
    parameter logic [7:0] SER_ADDR_DEFAULT = 8'h80,  // arbitrary value
    parameter logic [7:0] OWN_ADDR_DEFAULT = 8'h90,  // arbitrary value
    parameter int         REV_HOLD_CYCLES  = `REV_HOLD_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    input  wire logic       i_power_down_in_n,
    // register access from the control channel
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_register_write_block,
    output logic      [7:0] o_reg_rdata,
    output logic            o_reg_rvalid,
    // receiver events
    input  wire logic       i_symbol_valid,
    input  wire logic       i_symbol_err,
    input  wire logic       i_det_err,
    input  wire logic       i_corr_err,
    input  wire logic       i_relock_done,
    input  wire logic       i_video_link,
    output logic            o_relock_req,
    output logic            o_lock,
    // error thresholds and PRBS test
    input  wire logic [7:0] i_det_threshold,
    input  wire logic [7:0] i_corr_threshold,
    input  wire logic       i_prbs_mode,
    input  wire logic       i_prbs_err,
    // open-drain error flag
    output logic            o_err_out,
    output logic            o_err_oe,
    // control channel
    input  wire logic       i_serial_link_enable,
    input  wire logic       i_ack_req,
    input  wire logic       i_contention,
    output logic            o_forward_ctrl_chan_en,
    output logic            o_reverse_ctrl_chan_en,
    output logic            o_reverse_ctrl_chan_ready,
    output logic            o_ctrl_ack,
    // open-drain GPIO pins
    input  wire logic [1:0] i_pin_level,
    output logic      [1:0] o_pin_out,
    output logic      [1:0] o_pin_oe,
    // address copies and output staggering
    output logic      [7:0] o_serializer_addr,
    output logic      [7:0] o_own_addr,
    output logic            o_stagger_en
);

    localparam int AUTO_CLR_CYCLES = `AUTO_CLR_NS / `CLK_PERIOD_NS;

    // saturating increment shared by the three error counters
    function automatic logic [7:0] sat_inc(input logic [7:0] cnt, input logic ev);
        sat_inc = (ev && cnt != `ERR_CNT_MAX) ? cnt + 8'h01 : cnt;
    endfunction

    hk_state_t st_ff;
    hk_state_t nxt_st;

    // next-state logic for the whole block
    always_comb begin
        logic clr_det;
        logic clr_corr;
        logic auto_fire;
        logic wr_ok;
        logic [`WIN_CNT_W-1:0] err_n;
        clr_det   = 1'b0;
        clr_corr  = 1'b0;
        auto_fire = 1'b0;
        wr_ok     = 1'b0;
        err_n     = st_ff.win_err;
        nxt_st    = st_ff;

        if (!i_power_down_in_n) begin
            nxt_st.blocked = 1'b0;
        end else if (i_register_write_block) begin
            nxt_st.blocked = 1'b1;
        end
        // a write in the same cycle as the block request still lands
        wr_ok = i_reg_wr && !st_ff.blocked;

        // register writes
        if (wr_ok) begin
            unique case (i_reg_addr)
                `ADDR_SER_ADDR_COPY: nxt_st.ser_addr = i_reg_wdata;
                `ADDR_OWN_DEV_ADDR:  nxt_st.own_addr = i_reg_wdata;
                `ADDR_CTRL_CHAN_EN: begin
                    nxt_st.cc_en = {i_reg_wdata[`BIT_REV_CC_EN], i_reg_wdata[`BIT_FWD_CC_EN]};
                end
                `ADDR_OUT_ERR_OPTS: begin
                    nxt_st.auto_clr_en = i_reg_wdata[`BIT_AUTO_CLR_EN];
                    nxt_st.stagger_dis = i_reg_wdata[`BIT_STAGGER_DIS];
                end
                `ADDR_GPIO_STATE: begin
                    nxt_st.pin_out = {i_reg_wdata[`BIT_PIN1_OUT], i_reg_wdata[`BIT_PIN0_OUT]};
                end
                default: ;
            endcase
        end
        nxt_st.stagger_en = !nxt_st.stagger_dis;
        nxt_st.pin_oe = ~nxt_st.pin_out;

        // pin sampling, a bit changes once stages two and three agree
        nxt_st.pin_s1 = i_pin_level;
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.pin_s3 = st_ff.pin_s2;
        for (int i = 0; i < 2; i++) begin
            if (st_ff.pin_s2[i] == st_ff.pin_s3[i]) begin
                nxt_st.pin_lvl[i] = st_ff.pin_s3[i];
            end
        end

        if (i_reg_rd) begin
            clr_det  = (i_reg_addr == `ADDR_DET_ERR_CNT);
            clr_corr = (i_reg_addr == `ADDR_CORR_ERR_CNT);
        end

        // auto clear timer runs while flag is driven, except in PRBS mode
        if (st_ff.auto_clr_en && !i_prbs_mode && st_ff.err_drive) begin
            if (st_ff.auto_cnt == `AUTO_CNT_W'(AUTO_CLR_CYCLES - 1)) begin
                auto_fire       = 1'b1;
                nxt_st.auto_cnt = '0;
            end else begin
                nxt_st.auto_cnt = st_ff.auto_cnt + `AUTO_CNT_W'(1);
            end
        end else begin
            nxt_st.auto_cnt = '0;
        end

        // lock supervision over a window of symbols
        if (st_ff.lock) begin
            if (i_symbol_valid) begin
                err_n = st_ff.win_err + `WIN_CNT_W'(i_symbol_err);
                if (st_ff.win_sym == `ERR_WIN_SYMBOLS - `WIN_CNT_W'(1)) begin
                    // rate of a quarter or more drops lock; the window size is scaled down rather
                    // than the error count up, so a full window of errors cannot overflow the compare
                    nxt_st.lock    = err_n < (`ERR_WIN_SYMBOLS >> `ERR_RATE_DIV);
                    nxt_st.win_sym = '0;
                    nxt_st.win_err = '0;
                end else begin
                    nxt_st.win_sym = st_ff.win_sym + `WIN_CNT_W'(1);
                    nxt_st.win_err = err_n;
                end
            end
        end else if (i_relock_done) begin
            nxt_st.lock    = 1'b1;
            nxt_st.win_sym = '0;
            nxt_st.win_err = '0;
        end
        // registered copy so the relock request leaves straight from a flip-flop
        nxt_st.relock_req = !nxt_st.lock;

        // lock, read or auto clear zero counters
        if (clr_det || auto_fire || (i_relock_done && !st_ff.lock)) begin
            nxt_st.det_cnt = '0;
        end
        if (clr_corr || auto_fire || (i_relock_done && !st_ff.lock)) begin
            nxt_st.corr_cnt = '0;
        end
        if (i_prbs_mode) begin
            nxt_st.det_cnt  = '0;
            nxt_st.corr_cnt = '0;
        end else if (st_ff.lock) begin
            // count while locked, frozen otherwise; an event beats a clear
            nxt_st.det_cnt  = sat_inc(nxt_st.det_cnt, i_det_err);
            nxt_st.corr_cnt = sat_inc(nxt_st.corr_cnt, i_corr_err);
        end
        if (i_reg_rd && i_reg_addr == `ADDR_PRBS_ERR_CNT) begin
            nxt_st.prbs_cnt = '0;
        end
        nxt_st.prbs_cnt = sat_inc(nxt_st.prbs_cnt, i_prbs_mode && i_prbs_err);

        if (i_prbs_mode) begin
            nxt_st.err_drive = (st_ff.prbs_cnt != 8'h00);
        end else begin
            nxt_st.err_drive = (st_ff.det_cnt > i_det_threshold) || (st_ff.corr_cnt > i_corr_threshold);
        end

        // lock shown for video link only
        nxt_st.lock_out = st_ff.lock && i_video_link;

        // reverse channel hold after link toggle
        nxt_st.sen_d = i_serial_link_enable;
        if (i_serial_link_enable != st_ff.sen_d) begin
            nxt_st.rev_cnt = `REV_CNT_W'(REV_HOLD_CYCLES);
        end else if (st_ff.rev_cnt != '0) begin
            nxt_st.rev_cnt = st_ff.rev_cnt - `REV_CNT_W'(1);
        end
        nxt_st.rev_ready = (nxt_st.rev_cnt == '0) && nxt_st.cc_en[`BIT_REV_CC_EN];

        nxt_st.ack = i_ack_req && !i_contention;

        // register reads, answered one cycle later; reserved bits read zero
        nxt_st.rsp.valid = i_reg_rd;
        nxt_st.rsp.data  = 8'h00;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `ADDR_SER_ADDR_COPY: nxt_st.rsp.data = st_ff.ser_addr;
                `ADDR_OWN_DEV_ADDR:  nxt_st.rsp.data = st_ff.own_addr;
                `ADDR_CTRL_CHAN_EN:  nxt_st.rsp.data = {6'h00, st_ff.cc_en};
                `ADDR_OUT_ERR_OPTS: begin
                    nxt_st.rsp.data = {4'h0, st_ff.stagger_dis, st_ff.auto_clr_en, 2'h0};
                end
                `ADDR_GPIO_STATE: begin
                    nxt_st.rsp.data = {4'h0, st_ff.pin_out[1], st_ff.pin_lvl[1], st_ff.pin_out[0], st_ff.pin_lvl[0]};
                end
                `ADDR_DET_ERR_CNT:   nxt_st.rsp.data = st_ff.det_cnt;
                `ADDR_CORR_ERR_CNT:  nxt_st.rsp.data = st_ff.corr_cnt;
                `ADDR_PRBS_ERR_CNT:  nxt_st.rsp.data = st_ff.prbs_cnt;
                default:             nxt_st.rsp.data = 8'h00;
            endcase
        end
    end

    // state register; power-down input is taken as a plain level on this clock
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_ff             <= '0;
            st_ff.ser_addr    <= SER_ADDR_DEFAULT;
            st_ff.own_addr    <= OWN_ADDR_DEFAULT;
            st_ff.cc_en       <= `RST_CC_EN;
            st_ff.auto_clr_en <= `RST_AUTO_CLR_EN;
            st_ff.stagger_dis <= `RST_STAGGER_DIS;
            st_ff.stagger_en  <= 1'b1;
            st_ff.pin_out     <= `RST_PIN_OUT;
            st_ff.pin_lvl     <= 2'h3;
            // sync stages start at the pulled-up idle level, so reset shows no false low pin
            st_ff.pin_s1      <= 2'h3;
            st_ff.pin_s2      <= 2'h3;
            st_ff.pin_s3      <= 2'h3;
            st_ff.relock_req  <= 1'b1;
            st_ff.rev_ready   <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs, all from the state register except the open-drain data, which is tied always low
    assign o_reg_rdata               = st_ff.rsp.data;
    assign o_reg_rvalid              = st_ff.rsp.valid;
    assign o_relock_req              = st_ff.relock_req;
    assign o_lock                    = st_ff.lock_out;
    assign o_err_out                 = 1'b0;
    assign o_err_oe                  = st_ff.err_drive;
    assign o_forward_ctrl_chan_en    = st_ff.cc_en[`BIT_FWD_CC_EN];
    assign o_reverse_ctrl_chan_en    = st_ff.cc_en[`BIT_REV_CC_EN];
    assign o_reverse_ctrl_chan_ready = st_ff.rev_ready;
    assign o_ctrl_ack                = st_ff.ack;
    assign o_pin_out                 = 2'h0;
    assign o_pin_oe                  = st_ff.pin_oe;
    assign o_serializer_addr         = st_ff.ser_addr;
    assign o_own_addr                = st_ff.own_addr;
    // pads apply group delays when set
    assign o_stagger_en              = st_ff.stagger_en;

endmodule

// *** tb/hk_checker.sv ***
// assertions of the link housekeeping block, bound to every instance
// assumes one clock domain and the port names of link_housekeeping
`timescale 1ns/1ps

module hk_checker (
    // clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_reset,
    // watched inputs
    input wire logic       i_reg_rd,
    input wire logic       i_det_err,
    input wire logic       i_corr_err,
    input wire logic       i_relock_done,
    input wire logic       i_video_link,
    input wire logic       i_prbs_mode,
    input wire logic [7:0] i_det_threshold,
    input wire logic       i_serial_link_enable,
    input wire logic       i_ack_req,
    input wire logic       i_contention,
    // watched outputs
    input wire logic       o_reg_rvalid,
    input wire logic       o_relock_req,
    input wire logic       o_lock,
    input wire logic       o_err_out,
    input wire logic       o_err_oe,
    input wire logic [1:0] o_pin_out,
    input wire logic       o_reverse_ctrl_chan_en,
    input wire logic       o_reverse_ctrl_chan_ready,
    input wire logic       o_ctrl_ack
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    // a counted error over a zero threshold, then a cycle without any clear
    sequence det_hit_s;
        i_det_err && !o_relock_req && !i_prbs_mode && i_det_threshold == 8'h00;
    endsequence
    sequence no_clear_s;
        !i_reg_rd && !i_relock_done;
    endsequence
    // relock clears the counters; no new error may slip in behind it
    sequence relock_s;
        i_relock_done && o_relock_req && !i_det_err && !i_corr_err && !i_prbs_mode;
    endsequence

    read_answer_a: assert property (o_reg_rvalid == $past(i_reg_rd)) else $error("read answer misplaced");
    flag_raise_a: assert property (det_hit_s ##1 no_clear_s |=> o_err_oe) else $error("error flag late");
    flag_release_a: assert property (relock_s ##1 (!i_det_err && !i_corr_err && !i_prbs_mode) |=> !o_err_oe)
        else $error("error flag kept after relock");
    ack_given_a: assert property (i_ack_req && !i_contention |=> o_ctrl_ack) else $error("ack missing");
    ack_blocked_a: assert property (i_contention || !i_ack_req |=> !o_ctrl_ack) else $error("stray ack");
    lock_video_a: assert property (o_lock |-> $past(i_video_link)) else $error("lock outside video link");
    rev_hold_a: assert property ($changed(i_serial_link_enable) |=> ##1 !o_reverse_ctrl_chan_ready [*8])
        else $error("reverse channel ready too soon");
    chan_off_a: assert property (!o_reverse_ctrl_chan_en [*2] |-> !o_reverse_ctrl_chan_ready)
        else $error("reverse channel ready while off");
    pins_open_a: assert property (o_pin_out == 2'h0 && o_err_out == 1'b0) else $error("open drain drives high");
endmodule

bind link_housekeeping hk_checker u_hk_checker (.*);

// *** tb/link_partner.sv ***
// far side: remote serializer symbol stream and the receiver's relock answer
// assumes the bench raises i_bad to spoil symbols and i_hold to stall relock
`timescale 1ns/1ps

module link_partner (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    // commands and lock state
    input  wire logic i_relock_req,
    input  wire logic i_hold,
    input  wire logic i_slow,
    input  wire logic i_bad,
    // receiver events
    output logic      o_relock_done,
    output logic      o_symbol_valid,
    output logic      o_symbol_err
);
    logic [3:0] wait_ff;
    logic       phase_ff;

    // no UART rate steps: control strobes arrive decoded
    // one symbol every second cycle; a bad link spoils all, far above one in four
    always_ff @(posedge i_clk_sys) begin
        phase_ff       <= i_reset ? 1'b0 : ~phase_ff;
        o_symbol_valid <= phase_ff;
        o_symbol_err   <= phase_ff & i_bad;
    end

    // prompt or slow relock, one pulse per loss of lock
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || !i_relock_req || i_hold) begin
            wait_ff <= 4'h0;
        end else if (wait_ff != 4'hF) begin
            wait_ff <= wait_ff + 4'h1;
        end
        o_relock_done <= !i_reset && i_relock_req && !i_hold && wait_ff == (i_slow ? 4'hC : 4'h2);
    end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench of the link housekeeping block with the far-side model
// assumes design, checker and partner files are compiled before it
`timescale 1ns/1ps

module tb_top;
    localparam int REV_HOLD = 20;
    // design ports and bench state
    logic       i_clk_sys, i_reset, i_power_down_in_n, i_reg_wr, i_reg_rd, i_register_write_block;
    logic [7:0] i_reg_addr, i_reg_wdata, i_det_threshold, i_corr_threshold, o_reg_rdata;
    logic       i_symbol_valid, i_symbol_err, i_det_err, i_corr_err, i_relock_done, i_video_link;
    logic       i_prbs_mode, i_prbs_err, i_serial_link_enable, i_ack_req, i_contention, o_reg_rvalid;
    logic       o_relock_req, o_lock, o_err_out, o_err_oe, o_forward_ctrl_chan_en, o_reverse_ctrl_chan_en;
    logic       o_reverse_ctrl_chan_ready, o_ctrl_ack, o_stagger_en, hold, slow, bad;
    logic [1:0] i_pin_level, o_pin_out, o_pin_oe, ext_low;
    logic [7:0] o_serializer_addr, o_own_addr, d, a;
    int         n_mismatch, n_checks, seed, n;
    logic [7:0] def_a [6] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h0E, 8'h20};
    logic [7:0] def_v [6] = '{8'h80, 8'h90, 8'h03, 8'h00, 8'h0F, 8'h00};

    link_housekeeping #(.REV_HOLD_CYCLES(REV_HOLD)) dut (.*);
    link_partner partner (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_relock_req(o_relock_req),
        .i_hold(hold), .i_slow(slow), .i_bad(bad), .o_relock_done(i_relock_done),
        .o_symbol_valid(i_symbol_valid), .o_symbol_err(i_symbol_err));
    // pulled-up pins: low when the block or the outside world pulls
    assign i_pin_level = ~(o_pin_oe | ext_low);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        @(posedge i_clk_sys);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= ad;
        i_reg_wdata <= wd;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= ad;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1;
        chk({7'h0, o_reg_rvalid}, 8'h01);
        chk(o_reg_rdata, exp);
    endtask
    // back-to-back event pulses: bit 0 detected, 1 corrected, 2 test pattern
    task automatic fire(input logic [2:0] sel, input int cnt);
        repeat (cnt) begin
            @(posedge i_clk_sys);
            {i_prbs_err, i_corr_err, i_det_err} <= sel;
        end
        @(posedge i_clk_sys);
        {i_prbs_err, i_corr_err, i_det_err} <= 3'h0;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // free-running system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // hang guard: the whole sequence needs a little over a thousand cycles
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_mismatch++;
        results();
    end

    initial begin
        seed = 32'hc525;
        {i_reset, i_power_down_in_n, i_video_link, i_serial_link_enable} = 4'hF;
        {i_reg_wr, i_reg_rd, i_register_write_block, i_det_err, i_corr_err, i_prbs_err} = 6'h0;
        {i_prbs_mode, i_ack_req, i_contention, hold, slow, bad, ext_low} = 8'h0;
        {i_reg_addr, i_reg_wdata} = 16'h0;
        {i_det_threshold, i_corr_threshold} = 16'hFFFF;
        repeat (20) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        step(20);
        chk({5'h0, o_lock, o_stagger_en, o_forward_ctrl_chan_en}, 8'h07);
        foreach (def_a[k]) rd(def_a[k], def_v[k]);
        $display("defaults done");
        for (int k = 0; k < 4; k++) begin
            n = 1 + ($random(seed) & 15);
            fire(3'h1, n);
            fire(3'h2, n + 1);
            rd(8'h10, n[7:0]);
            rd(8'h10, 8'h00);
            rd(8'h12, 8'(n + 1));
        end
        fire(3'h1, 300);
        rd(8'h10, 8'hFF);
        $display("counters done");
        n = $random(seed) & 7;
        @(posedge i_clk_sys);
        i_det_threshold <= n[7:0];
        fire(3'h1, n);
        step(3);
        chk({7'h0, o_err_oe}, 8'h00);
        fire(3'h1, 1);
        step(120);
        chk({7'h0, o_err_oe}, 8'h01);
        rd(8'h10, 8'(n + 1));
        step(2);
        chk({7'h0, o_err_oe}, 8'h00);
        wr(8'h08, 8'h04);
        i_det_threshold <= 8'h00;
        fire(3'h1, 1);
        step(60);
        chk({7'h0, o_err_oe}, 8'h01);
        step(50);
        chk({7'h0, o_err_oe}, 8'h00);
        rd(8'h10, 8'h00);
        $display("error flag done");
        @(posedge i_clk_sys);
        i_prbs_mode <= 1'b1;
        fire(3'h1, 2);
        rd(8'h10, 8'h00);
        n = 1 + ($random(seed) & 3);
        fire(3'h4, n);
        step(120);
        chk({7'h0, o_err_oe}, 8'h01);
        rd(8'h13, n[7:0]);
        rd(8'h13, 8'h00);
        @(posedge i_clk_sys);
        i_prbs_mode     <= 1'b0;
        i_det_threshold <= 8'hFF;
        wr(8'h08, 8'h00);
        $display("test pattern done");
        fire(3'h1, 2);
        hold <= 1'b1;
        bad  <= 1'b1;
        for (n = 0; n < 80 && o_relock_req !== 1'b1; n++) step(1);
        chk({7'h0, o_relock_req}, 8'h01);
        @(posedge i_clk_sys);
        bad <= 1'b0;
        fire(3'h1, 3);
        rd(8'h10, 8'h02);
        @(posedge i_clk_sys);
        {slow, hold} <= 2'h2;
        step(30);
        chk({7'h0, o_lock}, 8'h01);
        @(posedge i_clk_sys);
        i_video_link <= 1'b0;
        step(3);
        chk({7'h0, o_lock}, 8'h00);
        @(posedge i_clk_sys);
        i_video_link <= 1'b1;
        $display("lock done");
        wr(8'h04, 8'h00);
        step(2);
        chk({6'h0, o_forward_ctrl_chan_en, o_reverse_ctrl_chan_en}, 8'h00);
        wr(8'h04, 8'h03);
        step(4);
        @(posedge i_clk_sys);
        i_serial_link_enable <= 1'b0;
        step(1);
        for (n = 0; n < REV_HOLD + 10 && o_reverse_ctrl_chan_ready !== 1'b1; n++) step(1);
        chk(8'(n), 8'(REV_HOLD));
        for (int k = 0; k < 24; k++) begin
            d = $random(seed);
            @(posedge i_clk_sys);
            i_ack_req    <= d[0];
            i_contention <= d[1];
            @(posedge i_clk_sys);
            i_ack_req <= 1'b0;
            #1;
            chk({7'h0, o_ctrl_ack}, {7'h0, d[0] & ~d[1]});
        end
        $display("control channel done");
        a = $random(seed);
        wr(8'h01, a);
        wr(8'h00, ~a);
        step(2);
        chk(o_own_addr, a);
        chk(o_serializer_addr, ~a);
        @(posedge i_clk_sys);
        i_register_write_block <= 1'b1;
        @(posedge i_clk_sys);
        i_register_write_block <= 1'b0;
        wr(8'h01, ~a);
        rd(8'h01, a);
        @(posedge i_clk_sys);
        i_power_down_in_n <= 1'b0;
        @(posedge i_clk_sys);
        i_power_down_in_n <= 1'b1;
        wr(8'h01, ~a);
        rd(8'h01, ~a);
        ext_low <= 2'h1;
        wr(8'h0E, 8'h02);
        step(6);
        chk({6'h0, o_pin_oe}, 8'h02);
        rd(8'h0E, 8'h02);
        ext_low <= 2'h0;
        wr(8'h0E, 8'h0A);
        step(6);
        rd(8'h0E, 8'h0F);
        wr(8'h08, 8'h08);
        step(2);
        chk({7'h0, o_stagger_en}, 8'h00);
        $display("registers done");
        results();
    end
endmodule
